// ### core/nvac_regs.svh
`ifndef NVAC_REGS_SVH
`define NVAC_REGS_SVH
// ==========================================
// Register map and fields
`define NVAC_CTRL_OFFSET 8'h40
`define NVAC_CTRL_SECTOR 8'h01
`define NVAC_BIT_FETCH_START 0
`define NVAC_BIT_FETCH_PERMIT 1
`define NVAC_BIT_PROG_START 2
`define NVAC_BIT_PROG_PERMIT 3
`define NVAC_CTRL_RESET 4'h0
`define NVAC_PTR_RESET 8'h00
`define NVAC_PROG_TICKS 16'h0040
`define NVAC_TICK_DIV 8'h0a
`define NVAC_FETCH_CYCLES 4'h2
`endif

// ### core/nvac_pkg.sv
package nvac_pkg;
  typedef enum logic [1:0] {
    NVAC_IDLE  = 2'b00,
    NVAC_FETCH = 2'b01,
    NVAC_PROG  = 2'b10
  } nvac_state_t;
endpackage : nvac_pkg

// ### core/nvac_array.sv
`timescale 1ns/1ps
// ==========================================
// Storage array, registered read data
module nvac_array #(
  parameter int AW = 8
) (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:(1<<AW)-1];
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
    if (rd_en) begin
      rdata <= mem[addr];
    end
  end
endmodule : nvac_array

// ### core/nvac_top.sv
`timescale 1ns/1ps
`include "nvac_regs.svh"
// Function
// - Reset clears the program permit bit so no write can start.
// - Reset zeroes both pointer pairs, keeping the control register out of reach.
// - Write completion sets the done flag and the multi-function request flag.
// - The vector request needs global, done and group enables with stack not full.
// - Servicing clears only the group flag; software clears the done flag.
// - Program start is ignored without permit and clears when the write ends.
// - Fetch start is ignored without permit; the byte holds until the next access.
// - Write length comes from a timer asynchronous to the system clock.
module nvac_top
  import nvac_pkg::*;
#(
  parameter int AW = 8,
  parameter logic [15:0] PROG_TICKS = `NVAC_PROG_TICKS
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic timer_tick,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [1:0] sfr_sel,
  input wire logic [7:0] sfr_wdata,
  input wire logic ind_wr,
  input wire logic ind_ptr,
  input wire logic [7:0] ind_wdata,
  input wire logic ptr_wr,
  input wire logic [1:0] ptr_sel,
  input wire logic [7:0] ptr_wdata,
  input wire logic global_irq_enable,
  input wire logic nvm_done_irq_enable,
  input wire logic mf_irq_enable,
  input wire logic stack_full,
  input wire logic irq_ack,
  input wire logic done_flag_clr,
  output logic [7:0] sfr_rdata,
  output logic [7:0] ind_rdata,
  output logic nvm_done_irq_flag,
  output logic mf_irq_flag,
  output logic irq_request
);
  // ==========================================
  // State and registers
  nvac_state_t state_reg, state_next;
  logic [3:0] nvm_control_reg, nvm_control_next;
  logic [AW-1:0] nvm_index_reg, nvm_index_next;
  logic [7:0] nvm_byte_reg, nvm_byte_next;
  logic [7:0] ptr_reg [0:3];
  logic [7:0] ptr_next [0:3];
  logic [15:0] tick_cnt_reg, tick_cnt_next;
  logic [3:0] fetch_cnt_reg, fetch_cnt_next;
  logic done_reg, done_next, mf_reg, mf_next, irq_reg, irq_next;
  logic [7:0] sfr_rdata_reg, sfr_rdata_next, ind_rdata_reg, ind_rdata_next;
  logic tick_s1_reg, tick_s2_reg, tick_s3_reg;
  logic prog_end, fetch_end, ind_hit, arr_wr, arr_rd;
  logic [7:0] arr_q;

  // Async timer tick: two flops, then edge detect on the second
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tick_s1_reg <= 1'b0;
      tick_s2_reg <= 1'b0;
      tick_s3_reg <= 1'b0;
    end else begin
      tick_s1_reg <= timer_tick;
      tick_s2_reg <= tick_s1_reg;
      tick_s3_reg <= tick_s2_reg;
    end
  end

  // ==========================================
  // Indirect access: pointer pair selects sector 1, offset 0x40
  always_comb begin
    ind_hit = ind_ptr ? (ptr_reg[3] == `NVAC_CTRL_SECTOR && ptr_reg[2] == `NVAC_CTRL_OFFSET)
                      : (ptr_reg[1] == `NVAC_CTRL_SECTOR && ptr_reg[0] == `NVAC_CTRL_OFFSET);
  end

  assign prog_end = (state_reg == NVAC_PROG) && (tick_cnt_reg == PROG_TICKS);
  assign fetch_end = (state_reg == NVAC_FETCH) && (fetch_cnt_reg == `NVAC_FETCH_CYCLES);
  assign arr_wr = prog_end;
  assign arr_rd = (state_reg == NVAC_FETCH) && (fetch_cnt_reg == 4'h0);

  always_comb begin
    state_next = state_reg;
    nvm_control_next = nvm_control_reg;
    nvm_index_next = nvm_index_reg;
    nvm_byte_next = nvm_byte_reg;
    tick_cnt_next = tick_cnt_reg;
    fetch_cnt_next = fetch_cnt_reg;
    for (int i = 0; i < 4; i++) begin
      ptr_next[i] = ptr_reg[i];
    end
    if (ptr_wr) begin
      ptr_next[ptr_sel] = ptr_wdata;
    end
    if (sfr_wr && sfr_sel == 2'b00) begin
      nvm_index_next = sfr_wdata[AW-1:0];
    end
    if (sfr_wr && sfr_sel == 2'b01) begin
      nvm_byte_next = sfr_wdata;
    end
    if (ind_wr && ind_hit) begin
      nvm_control_next[`NVAC_BIT_PROG_PERMIT] = ind_wdata[`NVAC_BIT_PROG_PERMIT];
      nvm_control_next[`NVAC_BIT_FETCH_PERMIT] = ind_wdata[`NVAC_BIT_FETCH_PERMIT];
      // Starts only take with permit already set; busy starts hold
      if (state_reg == NVAC_IDLE) begin
        if (ind_wdata[`NVAC_BIT_PROG_START] && nvm_control_reg[`NVAC_BIT_PROG_PERMIT]) begin
          nvm_control_next[`NVAC_BIT_PROG_START] = 1'b1;
          state_next = NVAC_PROG;
          tick_cnt_next = 16'h0000;
        end else if (ind_wdata[`NVAC_BIT_FETCH_START]
                     && nvm_control_reg[`NVAC_BIT_FETCH_PERMIT]) begin
          nvm_control_next[`NVAC_BIT_FETCH_START] = 1'b1;
          state_next = NVAC_FETCH;
          fetch_cnt_next = 4'h0;
        end
      end
    end
    case (state_reg)
      NVAC_IDLE: begin
      end
      NVAC_FETCH: begin
        fetch_cnt_next = fetch_cnt_reg + 4'h1;
        if (fetch_end) begin
          nvm_byte_next = arr_q;
          nvm_control_next[`NVAC_BIT_FETCH_START] = 1'b0;
          state_next = NVAC_IDLE;
        end
      end
      NVAC_PROG: begin
        // Duration set by async ticks, not ref_clk
        // A tick on the last count must not push the counter past its end
        if (tick_s2_reg && !tick_s3_reg && !prog_end) begin
          tick_cnt_next = tick_cnt_reg + 16'h0001;
        end
        if (prog_end) begin
          nvm_control_next[`NVAC_BIT_PROG_START] = 1'b0;
          state_next = NVAC_IDLE;
        end
      end
      default: begin
        state_next = NVAC_IDLE;
      end
    endcase
  end

  // ==========================================
  // Interrupt flags: hardware set wins over clear
  always_comb begin
    done_next = prog_end | (done_reg & ~done_flag_clr);
    mf_next = prog_end | (mf_reg & ~irq_ack);
    irq_next = mf_next & done_next & global_irq_enable & nvm_done_irq_enable
               & mf_irq_enable & ~stack_full;
    sfr_rdata_next = 8'h00;
    if (sfr_rd && sfr_sel == 2'b00) begin
      sfr_rdata_next = 8'(nvm_index_reg);
    end else if (sfr_rd && sfr_sel == 2'b01) begin
      sfr_rdata_next = nvm_byte_reg;
    end
    ind_rdata_next = ind_hit ? {4'h0, nvm_control_reg} : 8'h00;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg <= NVAC_IDLE;
      nvm_control_reg <= `NVAC_CTRL_RESET;
      nvm_index_reg <= '0;
      nvm_byte_reg <= 8'h00;
      for (int i = 0; i < 4; i++) begin
        ptr_reg[i] <= `NVAC_PTR_RESET;
      end
      tick_cnt_reg <= 16'h0000;
      fetch_cnt_reg <= 4'h0;
      done_reg <= 1'b0;
      mf_reg <= 1'b0;
      irq_reg <= 1'b0;
      sfr_rdata_reg <= 8'h00;
      ind_rdata_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      nvm_control_reg <= nvm_control_next;
      nvm_index_reg <= nvm_index_next;
      nvm_byte_reg <= nvm_byte_next;
      for (int i = 0; i < 4; i++) begin
        ptr_reg[i] <= ptr_next[i];
      end
      tick_cnt_reg <= tick_cnt_next;
      fetch_cnt_reg <= fetch_cnt_next;
      done_reg <= done_next;
      mf_reg <= mf_next;
      irq_reg <= irq_next;
      sfr_rdata_reg <= sfr_rdata_next;
      ind_rdata_reg <= ind_rdata_next;
    end
  end

  assign sfr_rdata = sfr_rdata_reg;
  assign ind_rdata = ind_rdata_reg;
  assign nvm_done_irq_flag = done_reg;
  assign mf_irq_flag = mf_reg;
  assign irq_request = irq_reg;

  nvac_array #(.AW(AW)) u_array (
    .ref_clk(ref_clk),
    .wr_en(arr_wr),
    .rd_en(arr_rd),
    .addr(nvm_index_reg),
    .wdata(nvm_byte_reg),
    .rdata(arr_q)
  );

  // ==========================================
  // Checks
  a_prog_needs_permit: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(nvm_control_reg[`NVAC_BIT_PROG_START]) |-> $past(nvm_control_reg[`NVAC_BIT_PROG_PERMIT]))
    else $error("program start without permit");
  a_fetch_needs_permit: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(nvm_control_reg[`NVAC_BIT_FETCH_START])
      |-> $past(nvm_control_reg[`NVAC_BIT_FETCH_PERMIT]))
    else $error("fetch start without permit");
  a_done_sets_flags: assert property (@(posedge ref_clk) disable iff (reset)
    prog_end |=> done_reg && mf_reg && !nvm_control_reg[`NVAC_BIT_PROG_START])
    else $error("write end did not set flags");
  a_ack_keeps_done: assert property (@(posedge ref_clk) disable iff (reset)
    irq_ack && done_reg && !done_flag_clr |=> done_reg)
    else $error("service cleared done flag");
  a_irq_gating: assert property (@(posedge ref_clk) disable iff (reset)
    irq_request |-> $past(global_irq_enable) && $past(nvm_done_irq_enable)
      && $past(mf_irq_enable) && !$past(stack_full))
    else $error("request without enables");
  a_fetch_len: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(nvm_control_reg[`NVAC_BIT_FETCH_START])
      |-> nvm_control_reg[`NVAC_BIT_FETCH_START][*3] ##1 !nvm_control_reg[`NVAC_BIT_FETCH_START])
    else $error("fetch length wrong");
  a_byte_holds: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg == NVAC_IDLE && !(sfr_wr && sfr_sel == 2'b01) |=> $stable(nvm_byte_reg))
    else $error("byte changed while idle");
  a_prog_tick_bound: assert property (@(posedge ref_clk) disable iff (reset)
    tick_cnt_reg <= PROG_TICKS)
    else $error("tick count overran");
endmodule : nvac_top

// ### verif/tb_top.sv
`timescale 1ns/1ps
`include "nvac_regs.svh"
// ==========================================
// Bench for the nonvolatile access control block
module tb_top;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic timer_tick = 1'b0;
  logic sfr_wr = 1'b0, sfr_rd = 1'b0, ind_wr = 1'b0, ind_ptr = 1'b0, ptr_wr = 1'b0;
  logic irq_ack = 1'b0, done_flag_clr = 1'b0;
  logic [1:0] sfr_sel = 2'h0, ptr_sel = 2'h0;
  logic [7:0] sfr_wdata = 8'h00, ind_wdata = 8'h00, ptr_wdata = 8'h00;
  // Enables: global, done, group, stack not full
  logic [3:0] en = 4'h0;
  logic [7:0] sfr_rdata, ind_rdata;
  logic nvm_done_irq_flag, mf_irq_flag, irq_request;
  int mismatches = 0;
  int n_compared = 0;

  nvac_top #(.AW(8), .PROG_TICKS(16'h0004)) uut (
    .ref_clk(ref_clk), .reset(reset), .timer_tick(timer_tick),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_sel(sfr_sel), .sfr_wdata(sfr_wdata),
    .ind_wr(ind_wr), .ind_ptr(ind_ptr), .ind_wdata(ind_wdata),
    .ptr_wr(ptr_wr), .ptr_sel(ptr_sel), .ptr_wdata(ptr_wdata),
    .global_irq_enable(en[3]), .nvm_done_irq_enable(en[2]), .mf_irq_enable(en[1]),
    .stack_full(~en[0]), .irq_ack(irq_ack), .done_flag_clr(done_flag_clr),
    .sfr_rdata(sfr_rdata), .ind_rdata(ind_rdata), .nvm_done_irq_flag(nvm_done_irq_flag),
    .mf_irq_flag(mf_irq_flag), .irq_request(irq_request)
  );

  initial forever #25 ref_clk = ~ref_clk;
  // Write timer free-runs, period unrelated to the system clock
  initial forever #185 timer_tick = ~timer_tick;

  // ==========================================
  // Access tasks
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Strobes are lowered only here, never twice in one step
  task idle(input int n);
    sfr_wr = 1'b0; sfr_rd = 1'b0; ind_wr = 1'b0; ptr_wr = 1'b0;
    irq_ack = 1'b0; done_flag_clr = 1'b0;
    repeat (n) @(negedge ref_clk);
  endtask : idle

  task ptr_write(input logic [1:0] s, input logic [7:0] d);
    ptr_wr = 1'b1; ptr_sel = s; ptr_wdata = d;
    @(negedge ref_clk);
  endtask : ptr_write

  task sector(input logic p, input logic [7:0] hi);
    ptr_write({p, 1'b0}, `NVAC_CTRL_OFFSET);
    ptr_write({p, 1'b1}, hi);
    idle(2);
  endtask : sector

  task ind_write(input logic [7:0] d);
    ind_wr = 1'b1; ind_wdata = d;
    @(negedge ref_clk);
  endtask : ind_write

  task sfr_write(input logic [1:0] s, input logic [7:0] d);
    sfr_wr = 1'b1; sfr_sel = s; sfr_wdata = d;
    @(negedge ref_clk);
  endtask : sfr_write

  task sfr_read(input logic [1:0] s, output logic [7:0] q);
    sfr_rd = 1'b1; sfr_sel = s;
    @(negedge ref_clk);
    q = sfr_rdata;
  endtask : sfr_read

  // Bounded wait for a start bit to drop; a hang counts as a mismatch
  task poll(input int b, output int k);
    k = 0;
    while (ind_rdata[b] !== 1'b0 && k < 300) begin
      @(negedge ref_clk);
      k++;
    end
    if (k == 300) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, ind_rdata, 8'h00);
    end
  endtask : poll

  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  initial begin
    #100000;
    mismatches++;
    end_sim();
  end

  // ==========================================
  // Tests
  initial begin
    logic [7:0] q;
    int k;
    repeat (8) @(negedge ref_clk);
    reset = 1'b0;
    idle(1);
    check(ind_rdata, 8'h00);
    check({5'h0, nvm_done_irq_flag, mf_irq_flag, irq_request}, 8'h00);
    ind_write(8'h08);
    idle(1);
    sector(1'b0, `NVAC_CTRL_SECTOR);
    check(ind_rdata, 8'h00);
    $display("test protection done");
    sfr_write(2'd0, 8'h05);
    sfr_write(2'd1, 8'ha5);
    ind_write(8'h04);
    idle(1);
    check(ind_rdata, 8'h00);
    ind_write(8'h0c);
    idle(1);
    check(ind_rdata, 8'h08);
    en = 4'h0;
    ind_write(8'h08);
    ind_write(8'h0c);
    idle(1);
    check(ind_rdata, 8'h0c);
    en = 4'h8;
    check({6'h0, nvm_done_irq_flag, mf_irq_flag}, 8'h00);
    poll(2, k);
    check({7'h0, k >= 15}, 8'h01);
    idle(1);
    check(ind_rdata, 8'h08);
    check({6'h0, nvm_done_irq_flag, mf_irq_flag}, 8'h03);
    $display("test write done");
    // Drop each enable in turn, then all set
    for (int i = 0; i < 5; i++) begin
      en = (i == 4) ? 4'hf : ~(4'h1 << i);
      idle(3);
      check({7'h0, irq_request}, {7'h0, i == 4});
    end
    irq_ack = 1'b1;
    @(negedge ref_clk);
    idle(1);
    check({6'h0, nvm_done_irq_flag, mf_irq_flag}, 8'h02);
    done_flag_clr = 1'b1;
    @(negedge ref_clk);
    idle(2);
    check({5'h0, nvm_done_irq_flag, mf_irq_flag, irq_request}, 8'h00);
    $display("test interrupt done");
    ind_write(8'h01);
    idle(1);
    check(ind_rdata, 8'h00);
    sfr_write(2'd1, 8'h00);
    ind_write(8'h02);
    ind_write(8'h03);
    idle(1);
    check(ind_rdata, 8'h03);
    poll(0, k);
    sfr_read(2'd1, q);
    idle(5);
    check(q, 8'ha5);
    sfr_read(2'd1, q);
    idle(1);
    check(q, 8'ha5);
    sfr_read(2'd0, q);
    idle(1);
    check(q, 8'h05);
    $display("test read done");
    ptr_write(2'd1, 8'h00);
    idle(2);
    check(ind_rdata, 8'h00);
    sector(1'b1, `NVAC_CTRL_SECTOR);
    ind_ptr = 1'b1;
    idle(2);
    check(ind_rdata, 8'h02);
    $display("test pointers done");
    // Mid-run reset with both permits set and pair 2 aimed at control
    ind_write(8'h0a);
    idle(2);
    check(ind_rdata, 8'h0a);
    reset = 1'b1;
    idle(2);
    reset = 1'b0;
    // Lands only if the pointers kept their old value
    ind_write(8'h08);
    idle(1);
    check(ind_rdata, 8'h00);
    sector(1'b1, `NVAC_CTRL_SECTOR);
    check(ind_rdata, 8'h00);
    $display("test reset done");
    end_sim();
  end
endmodule : tb_top
